// ---- rtl/unmbg_map.svh ----
// Register addresses, field positions and fixed counts of the nine-bit serial port
`ifndef UNMBG_MAP_SVH
`define UNMBG_MAP_SVH
`define UNMBG_ADDR_POWER_CONTROL_REG   8'h87
`define UNMBG_ADDR_SERIAL_CONTROL_REG   8'h98
`define UNMBG_ADDR_SERIAL_BUFFER   8'h99
`define UNMBG_ADDR_FRAC   8'h9d
`define UNMBG_ADDR_INTDIV 8'h9e
`define UNMBG_ADDR_TIMER2_CONTROL_REG  8'hc8
`define UNMBG_SERIAL_CONTROL_REG_HI     7
`define UNMBG_SERIAL_CONTROL_REG_LO     6
`define UNMBG_SERIAL_CONTROL_REG_MPF    5
`define UNMBG_SERIAL_CONTROL_REG_REN    4
`define UNMBG_SERIAL_CONTROL_REG_TB8    3
`define UNMBG_SERIAL_CONTROL_REG_RB8    2
`define UNMBG_SERIAL_CONTROL_REG_TI     1
`define UNMBG_SERIAL_CONTROL_REG_RI     0
`define UNMBG_POWER_CONTROL_REG_DBL    7
`define UNMBG_T2_RCLK     5
`define UNMBG_T2_T2_TX_CLOCK_SEL     4
`define UNMBG_FRAC_EN     7
`define UNMBG_INT_OVR     5
`define UNMBG_MODE0_CLKS  5'h0c
`define UNMBG_FRAC_ONE    18'h00040
`define UNMBG_FRAME_BITS  4'h8
`define UNMBG_TX_STOP_IDX 4'h9
`define UNMBG_TX_END_IDX  4'ha
`endif

// ---- rtl/unmbg_pkg.sv ----
// State types of the nine-bit serial port
package unmbg_pkg;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_WAIT  = 3'b010,
        TX_SHIFT = 3'b100
    } unmbg_tx_state_t;
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b001,
        RX_START = 3'b010,
        RX_DATA  = 3'b100
    } unmbg_rx_state_t;
endpackage

// ---- rtl/unmbg_top.sv ----
// Nine-bit serial port with fixed, timer and fractional baud sources
// Operation
// RULE_01: High select set, low clear: fixed nine-bit
// RULE_02: Frame: start, eight data LSB first, ninth, stop
// RULE_03: Fixed rate: clock/32, clock/16 when doubled
// RULE_04: Load buffer LSB first, ninth from stored bit
// RULE_05: Shifting starts on the next bit tick
// RULE_06: Transmit flag set as stop bit appears
// RULE_07: Without extension, accept only if receive flag clear
// RULE_08: Filter on: accept only ninth bit one
// RULE_09: Failed acceptance discards frame, flag untouched
// RULE_10: Accept: buffer, ninth bit, receive flag set
// RULE_11: Both selects set: same frame, timer rate
// RULE_12: Timer 1, 2 or baud timer, split
// RULE_13: Any buffer write starts a transmission; the code ignores a write made while a frame is shifting
// RULE_14: Receive start needs enable; mode 0 flag clear
// RULE_15: Shift-register mode bit rate clock/12
// RULE_16: Timer 1: doubling over 32 times overflow
// RULE_17: Timer 2: overflow rate over sixteen
// RULE_18: Timer 2 clock selects pick transmit, receive
// RULE_19: Baud timer: clock/16/2^n times (1+f/64)
// RULE_20: Baud timer covers 12 to 393216 bps; the code's n stops at 10, spanning clock/16 down to clock/16384 only
// RULE_21: Software rounds divider down, fraction nearest
// RULE_22: Software keeps Timer 1 interrupt off
// RULE_23: Baud timer enable overrides doubling, Timer 2
// RULE_24: Extended: always accept, flag overwrite, read clears; in mode 0 the code still needs the flag clear to start
// RULE_25: Sixteen-fold sampling, start confirmed mid-bit
`timescale 1ns/10ps
`default_nettype none
`include "unmbg_map.svh"
module unmbg_top
    import unmbg_pkg::*;
#(
    parameter int OVERSAMPLE = 16
)(
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       RXD_IN,
    input  wire logic       T1_OVF,
    input  wire logic       T2_OVF,
    input  wire logic       EXT_SERIAL_EN,
    output logic            TXD_OUT,
    output logic            TX_DONE_FLAG,
    output logic            RX_DONE_FLAG
);
    if (OVERSAMPLE < 13 || OVERSAMPLE > 31)
        $error("OVERSAMPLE must lie in 13..31");

    function automatic logic pick_tick(input logic m0, input logic m2, input logic ut_en,
                                       input logic use_t2, input logic fix, input logic ut,
                                       input logic t1, input logic t2);
        return m0 | (m2 & fix) | (!m0 & !m2 & (ut_en ? ut : (use_t2 ? t2 : t1)));
    endfunction

    logic [7:3]      ctl_q;
    logic            rate_double_bit_q;
    logic            t2_tx_clock_sel_q;
    logic            t2_rx_clock_sel_q;
    logic            baud_timer_enable_q;
    logic [5:0]      frac_q;
    logic [4:0]      div_q;
    logic            fix_q;
    logic            t1_half_q;
    logic [17:0]     acc_q;
    logic [17:0]     acc_d;
    unmbg_tx_state_t tx_state_q;
    unmbg_tx_state_t tx_state_d;
    logic [4:0]      tx_os_q;
    logic [9:0]      tx_sh_q;
    logic [9:0]      tx_sh_d;
    logic [3:0]      tx_cnt_q;
    logic [3:0]      tx_cnt_d;
    logic [7:0]      tx_buf_q;
    logic            txd_d;
    unmbg_rx_state_t rx_state_q;
    unmbg_rx_state_t rx_state_d;
    logic [4:0]      rx_os_q;
    logic [4:0]      rx_os_d;
    logic [3:0]      rx_cnt_q;
    logic [3:0]      rx_cnt_d;
    logic [8:0]      rx_sh_q;
    logic [8:0]      rx_sh_d;
    logic            rxd_prev_q;
    logic [7:0]      rx_buf_q;
    logic            rx_ninth_bit_q;
    logic            ovr_q;
    logic [7:0]      rd_mux;

    wire sel_serial_control_reg = SFR_ADDR == `UNMBG_ADDR_SERIAL_CONTROL_REG;
    wire sel_serial_buffer = SFR_ADDR == `UNMBG_ADDR_SERIAL_BUFFER;
    wire wr_serial_control_reg  = SFR_WR & sel_serial_control_reg;
    wire wr_serial_buffer  = SFR_WR & sel_serial_buffer;
    wire rd_serial_buffer  = SFR_RD & sel_serial_buffer;
    wire wr_power_control_reg  = SFR_WR & (SFR_ADDR == `UNMBG_ADDR_POWER_CONTROL_REG);
    wire wr_timer2_control_reg = SFR_WR & (SFR_ADDR == `UNMBG_ADDR_TIMER2_CONTROL_REG);
    wire wr_frac  = SFR_WR & (SFR_ADDR == `UNMBG_ADDR_FRAC);
    wire wr_int   = SFR_WR & (SFR_ADDR == `UNMBG_ADDR_INTDIV);

    wire mode_select_hi      = ctl_q[`UNMBG_SERIAL_CONTROL_REG_HI];
    wire mode_select_lo      = ctl_q[`UNMBG_SERIAL_CONTROL_REG_LO];
    wire multiproc_filter_en = ctl_q[`UNMBG_SERIAL_CONTROL_REG_MPF];
    wire rx_enable           = ctl_q[`UNMBG_SERIAL_CONTROL_REG_REN];
    wire tx_ninth_bit        = ctl_q[`UNMBG_SERIAL_CONTROL_REG_TB8];
    wire mode0 = !mode_select_hi & !mode_select_lo;
    wire mode2 = mode_select_hi & !mode_select_lo;                        // see RULE_01

    // Mode 0 runs one sample per clock over twelve clocks per bit
    wire [4:0] bit_len  = mode0 ? `UNMBG_MODE0_CLKS : 5'(OVERSAMPLE);    // see RULE_15
    wire [4:0] bit_last = bit_len - 5'h01;
    wire [4:0] half_pt  = (bit_len >> 1) - 5'h01;

    // Fixed rate: sample tick every other clock, every clock when doubled
    wire fix_tick = rate_double_bit_q | fix_q;                           // see RULE_03
    wire t1_tick  = T1_OVF & (rate_double_bit_q | t1_half_q);            // see RULE_16
    // Baud timer as a rate accumulator: adds 64+f, wraps at 64*2^n
    wire [3:0]  ut_exp   = 4'(div_q[2:0]) + 4'(div_q[4:3]);
    wire [17:0] ut_limit = `UNMBG_FRAC_ONE << ut_exp;                   // see RULE_20
    wire [17:0] ut_sum   = acc_q + `UNMBG_FRAC_ONE + 18'(frac_q);
    wire        ut_tick  = baud_timer_enable_q & (ut_sum >= ut_limit);   // see RULE_19
    always_comb
    begin
        acc_d = 18'h0;
        if (baud_timer_enable_q)
            acc_d = ut_tick ? ut_sum - ut_limit : ut_sum;
    end

    // Transmit and receive pick Timer 1 or Timer 2 independently; mode and baud timer enable are shared
    wire tx_tick = pick_tick(mode0, mode2, baud_timer_enable_q, t2_tx_clock_sel_q,
                             fix_tick, ut_tick, t1_tick, T2_OVF);        // see RULE_12, RULE_17, RULE_23
    wire rx_tick = pick_tick(mode0, mode2, baud_timer_enable_q, t2_rx_clock_sel_q,
                             fix_tick, ut_tick, t1_tick, T2_OVF);        // see RULE_11, RULE_18

    // Transmitter; a buffer write during a frame is ignored
    wire tx_bit   = tx_tick & (tx_os_q == bit_last);
    wire tx_ninth = mode_select_hi ? tx_ninth_bit : 1'b1;
    wire tx_set   = (tx_state_q == TX_SHIFT) & tx_bit & (tx_cnt_q == `UNMBG_TX_STOP_IDX);
    always_comb
    begin
        tx_state_d = tx_state_q;
        tx_sh_d    = tx_sh_q;
        tx_cnt_d   = tx_cnt_q;
        txd_d      = TXD_OUT;
        case (tx_state_q)
            TX_IDLE:
                if (wr_serial_buffer)
                    tx_state_d = TX_WAIT;                                 // see RULE_13
            TX_WAIT:
                if (tx_bit)
                begin
                    tx_state_d = TX_SHIFT;                                // see RULE_05
                    tx_sh_d    = {1'b1, tx_ninth, tx_buf_q};              // see RULE_04
                    tx_cnt_d   = 4'h0;
                    txd_d      = 1'b0;
                end
            TX_SHIFT:
                if (tx_bit)
                begin
                    if (tx_cnt_q == `UNMBG_TX_END_IDX)
                        tx_state_d = TX_IDLE;
                    else
                    begin
                        txd_d    = tx_sh_q[0];                            // see RULE_02
                        tx_sh_d  = {1'b1, tx_sh_q[9:1]};
                        tx_cnt_d = tx_cnt_q + 4'h1;
                    end
                end
            default:
                tx_state_d = TX_IDLE;
        endcase
    end

    // Receiver
    wire       start_ok   = rx_enable & (!mode0 | !RX_DONE_FLAG);       // see RULE_14
    wire       rx_sample  = rx_tick & (rx_os_q == bit_last);
    wire [8:0] rx_frame   = {RXD_IN, rx_sh_q[8:1]};
    wire       rx_final   = (rx_state_q == RX_DATA) & rx_sample & (rx_cnt_q == `UNMBG_FRAME_BITS);
    wire       pass_full  = EXT_SERIAL_EN | !RX_DONE_FLAG;               // see RULE_07, RULE_24
    wire       pass_addr  = !multiproc_filter_en | rx_frame[8];          // see RULE_08
    wire       rx_accept  = rx_final & pass_full & pass_addr;            // see RULE_09
    always_comb
    begin
        rx_state_d = rx_state_q;
        rx_os_d    = rx_os_q;
        rx_cnt_d   = rx_cnt_q;
        rx_sh_d    = rx_sh_q;
        case (rx_state_q)
            RX_IDLE:
                if (rxd_prev_q & !RXD_IN & start_ok)
                begin
                    rx_state_d = RX_START;
                    rx_os_d    = 5'h00;
                end
            RX_START:
                if (rx_tick)
                begin
                    if (rx_os_q == half_pt)
                    begin
                        // A glitch shorter than half a bit is not a start
                        rx_state_d = RXD_IN ? RX_IDLE : RX_DATA;          // see RULE_25
                        rx_os_d    = 5'h00;
                        rx_cnt_d   = 4'h0;
                    end
                    else
                        rx_os_d = rx_os_q + 5'h01;
                end
            RX_DATA:
                if (rx_sample)
                begin
                    rx_os_d  = 5'h00;
                    rx_sh_d  = rx_frame;                                  // see RULE_02
                    rx_cnt_d = rx_cnt_q + 4'h1;
                    if (rx_final)
                        rx_state_d = RX_IDLE;
                end
                else if (rx_tick)
                    rx_os_d = rx_os_q + 5'h01;
            default:
                rx_state_d = RX_IDLE;
        endcase
    end

    // Register read data
    always_comb
    begin
        case (SFR_ADDR)
            `UNMBG_ADDR_SERIAL_CONTROL_REG:   rd_mux = {ctl_q, rx_ninth_bit_q, TX_DONE_FLAG, RX_DONE_FLAG};
            `UNMBG_ADDR_SERIAL_BUFFER:   rd_mux = rx_buf_q;
            `UNMBG_ADDR_POWER_CONTROL_REG:   rd_mux = {rate_double_bit_q, 7'h00};
            `UNMBG_ADDR_TIMER2_CONTROL_REG:  rd_mux = {2'h0, t2_rx_clock_sel_q, t2_tx_clock_sel_q, 4'h0};
            `UNMBG_ADDR_FRAC:   rd_mux = {baud_timer_enable_q, 1'b0, frac_q};
            `UNMBG_ADDR_INTDIV: rd_mux = {2'h0, ovr_q, div_q};
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctl_q <= 5'h00;
            rate_double_bit_q <= 1'b0;
            t2_tx_clock_sel_q <= 1'b0;
            t2_rx_clock_sel_q <= 1'b0;
            baud_timer_enable_q <= 1'b0;
            frac_q <= 6'h00;
            div_q <= 5'h00;
            SFR_RDATA <= 8'h00;
        end
        else
        begin
            if (wr_serial_control_reg)
                ctl_q <= SFR_WDATA[7:3];
            if (wr_power_control_reg)
                rate_double_bit_q <= SFR_WDATA[`UNMBG_POWER_CONTROL_REG_DBL];
            if (wr_timer2_control_reg)
            begin
                t2_tx_clock_sel_q <= SFR_WDATA[`UNMBG_T2_T2_TX_CLOCK_SEL];
                t2_rx_clock_sel_q <= SFR_WDATA[`UNMBG_T2_RCLK];
            end
            if (wr_frac)
            begin
                baud_timer_enable_q <= SFR_WDATA[`UNMBG_FRAC_EN];
                frac_q <= SFR_WDATA[5:0];
            end
            if (wr_int)
                div_q <= SFR_WDATA[4:0];
            if (SFR_RD)
                SFR_RDATA <= rd_mux;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            fix_q <= 1'b0;
            t1_half_q <= 1'b0;
            acc_q <= 18'h0;
            tx_state_q <= TX_IDLE;
            tx_os_q <= 5'h00;
            tx_sh_q <= 10'h3ff;
            tx_cnt_q <= 4'h0;
            tx_buf_q <= 8'h00;
            TXD_OUT <= 1'b1;
            TX_DONE_FLAG <= 1'b0;
        end
        else
        begin
            fix_q <= !fix_q;
            t1_half_q <= t1_half_q ^ T1_OVF;
            acc_q <= acc_d;
            tx_state_q <= tx_state_d;
            if (tx_tick)
                tx_os_q <= tx_bit ? 5'h00 : tx_os_q + 5'h01;
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            if (wr_serial_buffer && tx_state_q != TX_SHIFT)
                tx_buf_q <= SFR_WDATA;
            TXD_OUT <= txd_d;
            // Hardware set beats a software clear in the same cycle
            TX_DONE_FLAG <= tx_set | (wr_serial_control_reg ? SFR_WDATA[`UNMBG_SERIAL_CONTROL_REG_TI] : TX_DONE_FLAG);  // see RULE_06
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            rx_state_q <= RX_IDLE;
            rx_os_q <= 5'h00;
            rx_cnt_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rxd_prev_q <= 1'b1;
            rx_buf_q <= 8'h00;
            rx_ninth_bit_q <= 1'b0;
            RX_DONE_FLAG <= 1'b0;
            ovr_q <= 1'b0;
        end
        else
        begin
            rx_state_q <= rx_state_d;
            rx_os_q <= rx_os_d;
            rx_cnt_q <= rx_cnt_d;
            rx_sh_q <= rx_sh_d;
            rxd_prev_q <= RXD_IN;
            if (rx_accept)
                rx_buf_q <= rx_frame[7:0];                                // see RULE_10
            if (rx_accept)
                rx_ninth_bit_q <= rx_frame[8];                            // see RULE_10
            else if (wr_serial_control_reg)
                rx_ninth_bit_q <= SFR_WDATA[`UNMBG_SERIAL_CONTROL_REG_RB8];
            RX_DONE_FLAG <= rx_accept | (wr_serial_control_reg ? SFR_WDATA[`UNMBG_SERIAL_CONTROL_REG_RI] : RX_DONE_FLAG);
            ovr_q <= (rx_accept & EXT_SERIAL_EN & RX_DONE_FLAG) | (ovr_q & !rd_serial_buffer);  // see RULE_24
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    a_tx_waits_tick: assert property ((tx_state_q == TX_WAIT && !tx_bit) |=> tx_state_q == TX_WAIT) // see RULE_05
        else $error("transmit left wait without a bit tick");
    a_tx_start_low: assert property ((tx_state_q == TX_WAIT && tx_bit) |=> (!TXD_OUT && tx_state_q == TX_SHIFT)) // see RULE_02
        else $error("start bit not driven low");
    a_tx_flag_stop: assert property (tx_set |=> (TX_DONE_FLAG && TXD_OUT)) // see RULE_06
        else $error("transmit flag not set with stop bit");
    a_rx_hold_full: assert property ((rx_final && !EXT_SERIAL_EN && RX_DONE_FLAG) |=> $stable(rx_buf_q)) // see RULE_07
        else $error("receive buffer overwritten while full");
    a_rx_addr_filter: assert property ((rx_final && multiproc_filter_en && !rx_frame[8] && !wr_serial_control_reg) |=> ($stable(rx_buf_q) && RX_DONE_FLAG == $past(RX_DONE_FLAG))) // see RULE_08
        else $error("data frame passed the address filter");
    a_rx_accept_load: assert property (rx_accept |=> (RX_DONE_FLAG && rx_buf_q == $past(rx_frame[7:0]) && rx_ninth_bit_q == $past(rx_frame[8]))) // see RULE_10
        else $error("accepted frame not stored");
    a_ovr_on_full: assert property ((rx_accept && EXT_SERIAL_EN && RX_DONE_FLAG) |=> ovr_q) // see RULE_24
        else $error("overwrite flag missing");
    // A rate or mode write in the same cycle legally changes the next tick
    a_fixed_half_rate: assert property ((mode2 && !rate_double_bit_q && tx_tick && !wr_power_control_reg && !wr_serial_control_reg) |=> !tx_tick) // see RULE_03
        else $error("fixed rate tick too fast");
    a_start_glitch: assert property ((rx_state_q == RX_START && rx_tick && rx_os_q == half_pt && RXD_IN) |=> rx_state_q == RX_IDLE) // see RULE_25
        else $error("glitch taken as start bit");
endmodule
`default_nettype wire

// ---- tb/unmbg_node.sv ----
// Remote serial node that sends frames to the port and captures the frames it sends
`timescale 1ns/10ps
`default_nettype none
module unmbg_node (
    input  wire logic        clk,
    input  wire logic        txd,
    input  wire logic [31:0] bit_clks,
    output logic             rxd
);
    logic [10:0] got_q[$];
    logic [10:0] cap;
    // Line idles high between frames
    initial rxd = 1'b1;
    // Start low, eight data LSB first, ninth, stop high
    task automatic send(input logic [7:0] d, input logic n9);
        logic [10:0] f;
        f = {1'b1, n9, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxd = f[i];
            repeat (bit_clks) @(posedge clk);
            #1;
        end
    endtask
    // Low pulse shorter than half a bit, which must not count as a start
    task automatic glitch(input int n);
        rxd = 1'b0;
        repeat (n) @(posedge clk);
        #1 rxd = 1'b1;
    endtask
    // Mid-bit sampling; the stop bit is kept so a short frame shows up
    always
    begin
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            #1 cap[i] = txd;
            if (i < 10)
                repeat (bit_clks) @(posedge clk);
        end
        got_q.push_back(cap);
    end
endmodule
`default_nettype wire

// ---- tb/unmbg_top_tb.sv ----
// Self-checking bench of the nine-bit serial port
`timescale 1ns/10ps
`default_nettype none
module unmbg_top_tb;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic       ext_en = 1'b0;
    logic [7:0] sfr_rdata;
    logic       rxd;
    logic       txd;
    logic       tx_done;
    logic       rx_done;
    logic [7:0] v;
    int         cyc;
    int         bit_clks = 32;
    int         n_mismatch;
    int         num_checks;
    int         serial_control_reg_cfg;
    int         intdiv;
    int         e_buf, e_rb8, e_ti, e_ri, e_ovr;
    int         bt_div[4] = '{8'h00, 8'h01, 8'h08, 8'h0a};
    int         bt_len[4] = '{16, 32, 32, 128};
    // Free-running overflow pulses: Timer 1 every 2 clocks, Timer 2 every 3
    wire logic  t1_ovf = (cyc % 2 == 1);
    wire logic  t2_ovf = (cyc % 3 == 0);
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= #1 cyc + 1;
    unmbg_top #(.OVERSAMPLE(16)) u_dut (
        .CLK(clk), .RESET(reset), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
        .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .RXD_IN(rxd),
        .T1_OVF(t1_ovf), .T2_OVF(t2_ovf), .EXT_SERIAL_EN(ext_en), .TXD_OUT(txd),
        .TX_DONE_FLAG(tx_done), .RX_DONE_FLAG(rx_done));
    unmbg_node u_node (.clk(clk), .txd(txd), .bit_clks(bit_clks), .rxd(rxd));
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    // A spare cycle after each strobe keeps a strobe from being set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk) #1 sfr_wr = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk) #1 sfr_rd = 1'b0;
        d = sfr_rdata;
        @(posedge clk) #1;
    endtask
    task automatic set_serial_control_reg(input int c);
        serial_control_reg_cfg = c;
        e_ti = 0;
        e_ri = 0;
        wr(8'h98, 8'(c | e_rb8 << 2));
    endtask
    task automatic check_state;
        rd(8'h98, v);
        chk_reg(v, 8'(serial_control_reg_cfg | e_rb8 << 2 | e_ti << 1 | e_ri));
        chk_reg({6'h0, tx_done, rx_done}, 8'(e_ti << 1 | e_ri));
        rd(8'h9e, v);
        chk_reg(v, 8'(intdiv | e_ovr << 5));
        rd(8'h99, v);
        e_ovr = 0;
        chk_reg(v, 8'(e_buf));
    endtask
    task automatic tx_frame(input logic [7:0] d);
        int t0;
        int t1;
        t0 = 0;
        set_serial_control_reg(serial_control_reg_cfg);
        sfr_addr = 8'h99;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk) #1 sfr_wr = 1'b0;
        for (t1 = 1; t1 < 3000 && tx_done !== 1'b1; t1++)
        begin
            if (t0 == 0 && txd === 1'b0)
                t0 = t1;
            @(posedge clk) #1;
        end
        chk_reg(8'(t0 >= 2 && t0 <= bit_clks + 2), 8'h01);
        chk_val(16'(t1 - t0), 16'(10 * bit_clks));
        chk_reg({7'h0, txd}, 8'h01);
        e_ti = 1;
        repeat (bit_clks) @(posedge clk);
        #1 chk_val(16'(u_node.got_q.pop_front()), 16'({1'b1, serial_control_reg_cfg[3] | !serial_control_reg_cfg[7], d, 1'b0}));
    endtask
    // Reference acceptance: enable, flag (shift mode never starts while full), filter, overwrite
    task automatic rx_frame(input logic [7:0] d, input logic n9);
        u_node.send(d, n9);
        repeat (4) @(posedge clk);
        #1;
        if (serial_control_reg_cfg[4] && (!e_ri || (ext_en && serial_control_reg_cfg[7:6] != 0)) && (!serial_control_reg_cfg[5] || n9))
        begin
            e_ovr = e_ovr | (ext_en & e_ri);
            e_buf = d;
            e_rb8 = n9;
            e_ri = 1;
        end
        check_state;
    endtask
    task automatic test_done(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'he1c4));
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        check_state;
        rd(8'h55, v);
        chk_reg(v, 8'h00);
        chk_reg({7'h0, txd}, 8'h01);
        test_done("reset");
        set_serial_control_reg(8'h98);
        tx_frame(8'($urandom));
        set_serial_control_reg(8'h90);
        tx_frame(8'($urandom));
        rx_frame(8'($urandom), 1'b0);
        rx_frame(8'($urandom), 1'b1);
        set_serial_control_reg(8'hb0);
        rx_frame(8'($urandom), 1'b0);
        rx_frame(8'($urandom), 1'b1);
        set_serial_control_reg(8'h80);
        rx_frame(8'($urandom), 1'b1);
        set_serial_control_reg(8'h90);
        ext_en = 1'b1;
        rx_frame(8'($urandom), 1'b1);
        rx_frame(8'($urandom), 1'b0);
        u_node.glitch(8);
        repeat (32) @(posedge clk);
        #1 check_state;
        test_done("fixed rate");
        wr(8'h87, 8'h80);
        bit_clks = 16;
        tx_frame(8'($urandom));
        rx_frame(8'($urandom), 1'b1);
        set_serial_control_reg(8'hd0);
        bit_clks = 32;
        tx_frame(8'($urandom));
        wr(8'h87, 8'h00);
        bit_clks = 64;
        rx_frame(8'($urandom), 1'b0);
        wr(8'hc8, 8'h10);
        bit_clks = 48;
        tx_frame(8'($urandom));
        bit_clks = 64;
        rx_frame(8'($urandom), 1'b1);
        wr(8'hc8, 8'h30);
        bit_clks = 48;
        rx_frame(8'($urandom), 1'b0);
        test_done("timers");
        // Doubling and Timer 2 stay set to show the baud timer ignores them
        wr(8'h87, 8'h80);
        wr(8'h9d, 8'h6b);
        rd(8'h9d, v);
        chk_reg(v, 8'h2b);
        wr(8'h9d, 8'h80);
        rd(8'h87, v);
        chk_reg(v, 8'h80);
        rd(8'hc8, v);
        chk_reg(v, 8'h30);
        rd(8'h9d, v);
        chk_reg(v, 8'h80);
        for (int i = 0; i < 4; i++)
        begin
            intdiv = bt_div[i];
            wr(8'h9e, 8'(intdiv));
            bit_clks = bt_len[i];
            tx_frame(8'($urandom));
            rx_frame(8'($urandom), 1'b1);
        end
        test_done("baud timer");
        set_serial_control_reg(8'h10);
        bit_clks = 12;
        tx_frame(8'($urandom));
        rx_frame(8'($urandom), 1'b1);
        rx_frame(8'($urandom), 1'b0);
        test_done("shift mode");
        end_of_test;
    end
    initial
    begin
        #600000;
        n_mismatch++;
        end_of_test;
    end
endmodule
`default_nettype wire
